// ==== hw/relay_seq_pkg.sv ====
// Purpose: Shared constants and carrier types for the relay sequencer
// Assumes: 100 MHz system clock
// Notes:   Timing counts derive from times in their own units
package relay_seq_pkg;

   localparam int CLK_HZ        = 100000000;
   localparam int DRIVE_TIME_MS = 8;
   localparam int DRIVE_CYCLES  = (CLK_HZ / 1000) * DRIVE_TIME_MS;
   localparam int QUEUE_DEPTH   = 8;
   localparam int QPTR_W        = 3;
   localparam int ROWS          = 4;
   localparam int COLS          = 4;
   localparam int CHANNELS      = 16;
   localparam int MUX_A_ROW_LAST = 1;
   localparam logic [3:0] RELAY_RESET_VALUE = 4'h0;

   // One queued row operation
   typedef struct packed {
      logic       is_close;
      logic [1:0] row;
      logic [3:0] bits;
   } row_cmd_t;

endpackage : relay_seq_pkg

// ==== hw/relay_matrix_interrupt.sv ====
// Purpose: Queue row commands, drive each for a fixed time, flag completion
// Assumes: Command strobe comes from logic on CLK_SYS
// Notes:   Queue full drops the write; host must poll CMD_FULL first
//
// What this block does
// RL1: Interrupt only when enable bit is set
// RL2: Interrupt after final queued operation completes
// RL3: Drive each row operation for 8 ms
// RL4: Complete only when timer expired, queue empty
// RL5: Spaced commands give one interrupt each
// RL6: Row r, column c is channel 4r+c
// RL7: Rows 0-1 mux A, rows 2-3 mux B
// RL8: Queue holds eight pending row operations
// RL9: Close ones, open zeros, others untouched
// RL10: Host checks queue full before writing
`timescale 1ns/1ns
`default_nettype none
module relay_matrix_interrupt #(
   parameter int DRIVE_CYCLES_P = relay_seq_pkg::DRIVE_CYCLES
) (
   // Clock and reset
   input  wire logic                     CLK_SYS,
   input  wire logic                     NRST,
   // Control
   input  wire logic                     IRQ_ENABLE_BIT,
   // Command port
   input  wire logic                     CMD_WR,
   input  wire relay_seq_pkg::row_cmd_t  CMD_DATA,
   output logic                          CMD_FULL,
   output logic                          CMD_EMPTY,
   // Relay drive
   output logic                          DRIVE_ACTIVE,
   output logic [3:0]                    DRIVE_ROW_ONEHOT,
   output logic [15:0]                   CHANNEL_CLOSED,
   output logic [7:0]                    MUX_A_CLOSED,
   output logic [7:0]                    MUX_B_CLOSED,
   // Interrupt toward carrier
   output logic                          INT_REQ
);

   typedef enum logic [1:0] {IDLE, LOAD, DRIVE} seq_state_t;

   relay_seq_pkg::row_cmd_t queue_r [relay_seq_pkg::QUEUE_DEPTH];
   logic [2:0]        wptr_r;
   logic [2:0]        rptr_r;
   logic [3:0]        count_r;
   seq_state_t        state_r;
   logic [22:0]       timer_r;
   relay_seq_pkg::row_cmd_t cur_r;
   logic [15:0]       chan_r;
   logic              int_r;
   logic              active_r;
   logic [3:0]        row_oh_r;
   logic              full_r;
   logic              empty_r;

   // Channel index from row and column
   function automatic logic [3:0] chan_idx(input logic [1:0] r,
                                           input logic [1:0] c);
      chan_idx = {r, c}; // [RL6]
   endfunction : chan_idx

   wire logic push     = CMD_WR && (count_r != 4'(relay_seq_pkg::QUEUE_DEPTH));
   wire logic pop      = (state_r == IDLE) && (count_r != 4'h0);
   wire logic time_up  = (timer_r == 23'(DRIVE_CYCLES_P - 1));
   wire logic finish   = (state_r == DRIVE) && time_up;
   wire logic [3:0] cnt_nxt = count_r + 4'(push) - 4'(pop);
   wire logic [3:0] cur_row_oh = 4'h1 << cur_r.row;
   // Driven row as a mask; a wrong channel index shows up outside it
   wire logic [15:0] row_mask = {{4{row_oh_r[3]}}, {4{row_oh_r[2]}},
                                 {4{row_oh_r[1]}}, {4{row_oh_r[0]}}};

   // Apply one row operation to the relay image
   logic [15:0] chan_nxt;
   always_comb begin
      chan_nxt = chan_r;
      for (int c = 0; c < relay_seq_pkg::COLS; c++) begin
         if (cur_r.is_close && cur_r.bits[c])
            chan_nxt[chan_idx(cur_r.row, 2'(c))] = 1'b1; // [RL9]
         else if (!cur_r.is_close && !cur_r.bits[c])
            chan_nxt[chan_idx(cur_r.row, 2'(c))] = 1'b0; // [RL9]
      end
   end

   // Queue storage; a write when full is dropped
   always_ff @(posedge CLK_SYS) begin
      if (push)
         queue_r[wptr_r] <= CMD_DATA; // [RL8] [RL10]
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         wptr_r   <= 3'h0;
         rptr_r   <= 3'h0;
         count_r  <= 4'h0;
         full_r   <= 1'b0;
         empty_r  <= 1'b1;
      end else begin
         if (push)
            wptr_r <= wptr_r + 3'h1;
         if (pop)
            rptr_r <= rptr_r + 3'h1;
         count_r <= cnt_nxt; // [RL8]
         full_r  <= (cnt_nxt == 4'(relay_seq_pkg::QUEUE_DEPTH));
         empty_r <= (cnt_nxt == 4'h0);
      end
   end

   // Sequencer: one op at a time, timed drive
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         state_r  <= IDLE;
         timer_r  <= 23'h0;
         cur_r    <= '0;
         chan_r   <= {4{relay_seq_pkg::RELAY_RESET_VALUE}};
         active_r <= 1'b0;
         row_oh_r <= 4'h0;
      end else begin
         case (state_r)
            IDLE: begin
               if (pop) begin
                  cur_r   <= queue_r[rptr_r];
                  state_r <= LOAD;
               end
            end
            LOAD: begin
               chan_r   <= chan_nxt;
               timer_r  <= 23'h0;
               active_r <= 1'b1;
               row_oh_r <= cur_row_oh;
               state_r  <= DRIVE;
            end
            DRIVE: begin
               timer_r <= timer_r + 23'h1; // [RL3]
               if (time_up) begin
                  active_r <= 1'b0;
                  row_oh_r <= 4'h0;
                  state_r  <= IDLE;
               end
            end
            default: state_r <= IDLE;
         endcase
      end
   end

   // Completion: timer done and nothing waiting; held until next op
   // starts, so back-to-back writes give one request only
   always_ff @(posedge CLK_SYS) begin
      if (!NRST)
         int_r <= 1'b0;
      else if (!IRQ_ENABLE_BIT)
         int_r <= 1'b0; // [RL1]
      else if (finish && count_r == 4'h0 && !push)
         int_r <= 1'b1; // [RL2] [RL4] [RL5]
      else if (pop)
         int_r <= 1'b0;
   end

   assign CMD_FULL         = full_r;
   assign CMD_EMPTY        = empty_r;
   assign DRIVE_ACTIVE     = active_r;
   assign DRIVE_ROW_ONEHOT = row_oh_r;
   assign CHANNEL_CLOSED   = chan_r;
   assign MUX_A_CLOSED     = chan_r[7:0];  // [RL7]
   assign MUX_B_CLOSED     = chan_r[15:8]; // [RL7]
   assign INT_REQ          = int_r;

   sequence s_load;
      state_r == LOAD;
   endsequence

   sequence s_drive_start;
      $rose(DRIVE_ACTIVE);
   endsequence

   a_int_needs_enable: assert property ( // [RL1]
      @(posedge CLK_SYS) disable iff (!NRST)
      INT_REQ |-> $past(IRQ_ENABLE_BIT))
      else $error("interrupt without enable");
   a_int_after_last: assert property ( // [RL2]
      @(posedge CLK_SYS) disable iff (!NRST)
      (finish && count_r == 4'h0 && !push && IRQ_ENABLE_BIT)
      ##1 IRQ_ENABLE_BIT |-> INT_REQ)
      else $error("interrupt missing after last op");
   a_drive_length: assert property ( // [RL3]
      @(posedge CLK_SYS) disable iff (!NRST)
      s_load ##1 1'b1 |-> DRIVE_ACTIVE throughout (state_r == DRIVE)[*8])
      else $error("drive ended early");
   a_timer_cap: assert property ( // [RL3]
      @(posedge CLK_SYS) disable iff (!NRST)
      state_r == DRIVE |-> timer_r < 23'(DRIVE_CYCLES_P))
      else $error("drive timer overran");
   a_no_int_pending: assert property ( // [RL4]
      @(posedge CLK_SYS) disable iff (!NRST)
      $rose(INT_REQ) |-> $past(finish) && ($past(count_r) == 4'h0))
      else $error("interrupt with queue pending");
   a_int_per_op: assert property ( // [RL5]
      @(posedge CLK_SYS) disable iff (!NRST)
      (pop && INT_REQ) |=> !INT_REQ)
      else $error("interrupt not cleared by new op");
   a_mux_split: assert property ( // [RL6] [RL7]
      @(posedge CLK_SYS) disable iff (!NRST)
      {MUX_B_CLOSED, MUX_A_CLOSED} == CHANNEL_CLOSED)
      else $error("mux split mismatch");
   a_queue_bound: assert property ( // [RL8]
      @(posedge CLK_SYS) disable iff (!NRST)
      count_r <= 4'(relay_seq_pkg::QUEUE_DEPTH)
      && (CMD_FULL == (count_r == 4'h8)))
      else $error("queue count out of range");
   a_close_bits: assert property ( // [RL9]
      @(posedge CLK_SYS) disable iff (!NRST)
      (s_load ##0 cur_r.is_close) |=>
      (CHANNEL_CLOSED | $past(chan_r)) == CHANNEL_CLOSED)
      else $error("close op opened a relay");
   a_open_bits: assert property ( // [RL9]
      @(posedge CLK_SYS) disable iff (!NRST)
      (s_load ##0 !cur_r.is_close) |=>
      (CHANNEL_CLOSED & $past(chan_r)) == CHANNEL_CLOSED)
      else $error("open op closed a relay");
   a_row_only: assert property ( // [RL6]
      @(posedge CLK_SYS) disable iff (!NRST)
      s_drive_start |->
      ((CHANNEL_CLOSED ^ $past(CHANNEL_CLOSED)) & ~row_mask) == 16'h0)
      else $error("relay moved outside driven row");
   a_mux_b_hold: assert property ( // [RL7]
      @(posedge CLK_SYS) disable iff (!NRST)
      (s_drive_start ##0 (DRIVE_ROW_ONEHOT[3:2] == 2'h0))
      |-> $stable(MUX_B_CLOSED))
      else $error("mux B moved on a mux A row");
   a_mux_a_hold: assert property ( // [RL7]
      @(posedge CLK_SYS) disable iff (!NRST)
      (s_drive_start ##0 (DRIVE_ROW_ONEHOT[1:0] == 2'h0))
      |-> $stable(MUX_A_CLOSED))
      else $error("mux A moved on a mux B row");

endmodule : relay_matrix_interrupt
`default_nettype wire

// ==== tb/carrier_model.sv ====
// Purpose: Carrier bus side, writes row commands
// Assumes: Requests change on the falling edge
// Notes:   Holds off while full, so no write is lost
`timescale 1ns/1ns
`default_nettype none
module carrier_model (
   // Clock and status
   input  wire logic                    clk,
   input  wire logic                    full,
   // Request from bench
   input  wire logic                    go,
   input  wire relay_seq_pkg::row_cmd_t cmd_in,
   // Command port
   output var  logic                    wr,
   output var  relay_seq_pkg::row_cmd_t cmd
);
   always @(negedge clk) begin
      wr  <= go && !full;
      cmd <= cmd_in;
   end
endmodule : carrier_model
`default_nettype wire

// ==== tb/relay_matrix_interrupt_tb_top.sv ====
// Purpose: Scenario bench for the relay sequencer
// Assumes: Short drive count of 20 cycles
// Notes:   Waits are bounded; a stuck wait ends the run
`timescale 1ns/1ns
`default_nettype none
module relay_matrix_interrupt_tb_top;
   logic CLK_SYS = 0, NRST = 0, IRQ_ENABLE_BIT = 0, go = 0, CMD_WR;
   relay_seq_pkg::row_cmd_t cmd = 0, CMD_DATA;
   logic CMD_FULL, CMD_EMPTY, DRIVE_ACTIVE, INT_REQ, int_d = 0;
   logic [3:0]  DRIVE_ROW_ONEHOT;
   logic [15:0] CHANNEL_CLOSED;
   logic [7:0]  MUX_A_CLOSED, MUX_B_CLOSED;
   logic [3:0]  rows_seen = 0;
   int err_count = 0, cmp_count = 0, ints = 0, act = 0, fulls = 0;

   relay_matrix_interrupt #(.DRIVE_CYCLES_P(20)) dut (.CLK_SYS,
      .NRST, .IRQ_ENABLE_BIT, .CMD_WR, .CMD_DATA, .CMD_FULL,
      .CMD_EMPTY, .DRIVE_ACTIVE, .DRIVE_ROW_ONEHOT, .CHANNEL_CLOSED,
      .MUX_A_CLOSED, .MUX_B_CLOSED, .INT_REQ);
   carrier_model host (.clk(CLK_SYS), .full(CMD_FULL), .go(go),
      .cmd_in(cmd), .wr(CMD_WR), .cmd(CMD_DATA));

   initial begin
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   // Counts interrupt edges, drive cycles and full sightings
   always @(posedge CLK_SYS) begin
      ints  = ints + (INT_REQ & !int_d);
      act   = act + DRIVE_ACTIVE;
      fulls = fulls + CMD_FULL;
      rows_seen = rows_seen | DRIVE_ROW_ONEHOT;
      int_d = INT_REQ;
   end

   task chk(string n, logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task results;
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   task send(logic c, logic [1:0] r, logic [3:0] b);
      @(negedge CLK_SYS);
      cmd <= {c, r, b};
      go  <= 1'b1;
      @(negedge CLK_SYS);
      go  <= 1'b0;
   endtask : send
   // Idle must hold a few cycles: empty shows before drive starts
   task idle;
      int n;
      n = 0;
      for (int i = 0; i < 3000 && n < 5; i++) begin
         @(negedge CLK_SYS);
         n = (CMD_EMPTY && !DRIVE_ACTIVE) ? n + 1 : 0;
      end
      if (n < 5) begin
         err_count++;
         results;
      end
   endtask : idle

   task t_map;
      IRQ_ENABLE_BIT = 1;
      act = 0;
      rows_seen = 0;
      send(1, 1, 4'h1);
      idle;
      chk("act", 16'(act), 16'd20);
      chk("chan", CHANNEL_CLOSED, 16'h0010);
      chk("muxa", 16'(MUX_A_CLOSED), 16'h0010);
      chk("rows", 16'(rows_seen), 16'h0002);
      chk("int", 16'(INT_REQ), 16'h1);
      send(1, 3, 4'h8);
      send(0, 1, 4'he);
      send(1, 2, 4'h0);
      idle;
      chk("muxb", 16'(MUX_B_CLOSED), 16'h0080);
      chk("chan", CHANNEL_CLOSED, 16'h8000);
   endtask : t_map
   task t_burst;
      ints = 0;
      act = 0;
      rows_seen = 0;
      for (int r = 0; r < 4; r++) send(0, 2'(r), 4'hf);
      idle;
      chk("ints", 16'(ints), 16'd1);
      chk("act", 16'(act), 16'd80);
      chk("rows", 16'(rows_seen), 16'h000f);
      ints = 0;
      send(0, 0, 4'hf);
      idle;
      send(0, 1, 4'hf);
      idle;
      chk("ints", 16'(ints), 16'd2);
   endtask : t_burst
   task t_off;
      IRQ_ENABLE_BIT = 0;
      ints = 0;
      send(1, 0, 4'h3);
      idle;
      chk("ints", 16'(ints), 16'd0);
      chk("int", 16'(INT_REQ), 16'h0);
      IRQ_ENABLE_BIT = 1;
      fulls = 0;
      @(negedge CLK_SYS);
      go <= 1'b1;
      repeat (12) @(negedge CLK_SYS);
      go <= 1'b0;
      idle;
      chk("full", 16'(fulls > 0), 16'h1);
      chk("chan", CHANNEL_CLOSED, 16'h8003);
   endtask : t_off
   // Reset state: queue empty, nothing driven, relay image cleared
   task rst_chk;
      chk("rst empty", 16'(CMD_EMPTY), 16'h1);
      chk("rst full", 16'(CMD_FULL), 16'h0);
      chk("rst act", 16'(DRIVE_ACTIVE), 16'h0);
      chk("rst row", 16'(DRIVE_ROW_ONEHOT), 16'h0);
      chk("rst int", 16'(INT_REQ), 16'h0);
      chk("rst chan", CHANNEL_CLOSED, 16'h0);
   endtask : rst_chk
   // Reset in mid drive, then one op must still run cleanly
   task t_reset;
      send(1, 2, 4'hf);
      repeat (4) @(negedge CLK_SYS);
      chk("mid act", 16'(DRIVE_ACTIVE), 16'h1);
      NRST = 0;
      repeat (2) @(negedge CLK_SYS);
      rst_chk;
      NRST = 1;
      rows_seen = 0;
      send(1, 0, 4'h1);
      idle;
      chk("chan", CHANNEL_CLOSED, 16'h0001);
      chk("rows", 16'(rows_seen), 16'h0001);
      chk("int", 16'(INT_REQ), 16'h1);
   endtask : t_reset

   initial begin
      repeat (20) @(negedge CLK_SYS);
      rst_chk;
      NRST = 1;
      t_map;
      t_burst;
      t_off;
      t_reset;
      results;
   end
endmodule : relay_matrix_interrupt_tb_top
`default_nettype wire
